//--- pkg/srlm_consts.svh
`ifndef SRLM_CONSTS_SVH
`define SRLM_CONSTS_SVH
// ==========================================================================
// Register offsets
`define SRLM_OFF_IRQ_EN 8'h20
`define SRLM_OFF_IRQ_STAT 8'h24
`define SRLM_OFF_DSET_FRM 8'h31
`define SRLM_OFF_DSET_LO 8'h32
`define SRLM_OFF_DSET_HI 8'h33
`define SRLM_OFF_MEAS_LO 8'h34
`define SRLM_OFF_MEAS_HI 8'h35
`define SRLM_OFF_TALLY 8'h36
`define SRLM_OFF_PHASE_LO 8'h37
`define SRLM_OFF_PHASE_HI 8'h38
`define SRLM_OFF_JIT_ALLOW 8'h39
`define SRLM_OFF_ALIGN_CTRL 8'h3a
`define SRLM_OFF_TX_GATE 8'h3f
// ==========================================================================
// Field positions and codes
`define SRLM_BIT_JITTER 4
`define SRLM_BIT_GATE_OUT 7
`define SRLM_BIT_GATE_IN 6
`define SRLM_MODE_MONITOR 2'h0
`define SRLM_MODE_CONT 2'h1
`define SRLM_MODE_ONESHOT 2'h2
// ==========================================================================
// Reset values
`define SRLM_RST_GATE 1'h1
`define SRLM_RST_ZERO8 8'h00
// ==========================================================================
// Timing counts in DAC clock cycles
`define SRLM_FRAME_CYCLES 13'h004
`define SRLM_LMFC_PERIOD 12'h080
`endif

//--- pkg/srlm_pkg.sv
// ==========================================================================
// Types shared by the alignment monitor.
package srlm_pkg;
  typedef enum logic [1:0] {
    SRLM_ALIGN_IDLE = 2'b00,
    SRLM_ALIGN_COUNT = 2'b01
  } srlm_align_state_type;

  typedef struct packed {
    logic [4:0] dset_frm;
    logic [11:0] dset_cyc;
    logic [5:0] jit_allow;
    logic [1:0] mode;
    logic gate_out;
    logic gate_in;
    logic jit_irq_en;
  } srlm_cfg_type;

  typedef struct packed {
    logic [11:0] delay;
    logic [11:0] phase;
  } srlm_meas_type;
endpackage : srlm_pkg

//--- hw/srlm_top.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "srlm_consts.svh"
module srlm_top
  import srlm_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Reference pulse pin
  input wire logic SYSREF,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Data gating
  input wire logic [15:0] LANE_DATA,
  output logic [15:0] DP_IN_DATA,
  input wire logic [15:0] DP_OUT_DATA,
  output logic [15:0] DAC_DATA,
  // Status
  output logic LMFC_EDGE,
  output logic IRQ
);

  // ==========================================================================
  // Reset release and reference pin synchroniser
  // ==========================================================================
  logic rst_meta_reg;
  logic rst_n_sync;
  logic ref_meta_reg;
  logic ref_sync_reg;
  logic ref_prev_reg;
  logic ref_edge;

  // Reset is asserted at once and released two edges later.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync <= rst_meta_reg;
    end
  end

  // The pin is asynchronous, so the first stage feeds nothing but the second stage.
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ref_meta_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else begin
      ref_meta_reg <= SYSREF;
      ref_sync_reg <= ref_meta_reg;
      ref_prev_reg <= ref_sync_reg;
    end
  end

  assign ref_edge = ref_sync_reg & ~ref_prev_reg;

  // ==========================================================================
  // State
  // ==========================================================================
  srlm_cfg_type cfg_reg, cfg_next;
  srlm_meas_type live_reg, live_next;
  srlm_meas_type snap_reg, snap_next;
  srlm_align_state_type align_reg, align_next;
  logic [12:0] align_cnt_reg, align_cnt_next;
  logic [11:0] lmfc_cnt_reg, lmfc_cnt_next;
  logic [11:0] meas_cnt_reg, meas_cnt_next;
  logic meas_act_reg, meas_act_next;
  logic have_prev_reg, have_prev_next;
  logic [7:0] tally_reg, tally_next;
  logic jit_flag_reg, jit_flag_next;
  logic [7:0] rdata_next;
  logic [15:0] dp_in_next;
  logic [15:0] dac_next;
  logic irq_next;
  logic lmfc_edge;
  logic jit_evt;
  logic wr_snap;
  logic [11:0] diff;
  logic [11:0] allow_thr;
  logic [12:0] target;
  logic [3:0] ph_cnt;
  logic [11:0] thermo;

  assign lmfc_edge = (lmfc_cnt_reg == 12'h000);
  assign wr_snap = REG_WR && (REG_ADDR == `SRLM_OFF_MEAS_LO || REG_ADDR == `SRLM_OFF_MEAS_HI ||
                              REG_ADDR == `SRLM_OFF_PHASE_LO || REG_ADDR == `SRLM_OFF_PHASE_HI);
  // Frames are expanded to clock cycles; the sum cannot overflow 13 bits.
  assign target = 13'(cfg_reg.dset_frm) * `SRLM_FRAME_CYCLES + 13'(cfg_reg.dset_cyc);
  // The phase is the frame-clock position at the pulse, clipped to twelve steps.
  assign ph_cnt = (lmfc_cnt_reg[3:0] > 4'hc) ? 4'hc : lmfc_cnt_reg[3:0];

  // ==========================================================================
  // Thermometer encoder, one generate loop over the phase bits
  // ==========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_thermo
      assign thermo[gi] = (ph_cnt > 4'(gi));
    end
  endgenerate

  // ==========================================================================
  // Jitter comparison
  // ==========================================================================
  always_comb begin
    diff = (live_next.delay > live_reg.delay) ? (live_next.delay - live_reg.delay)
                                              : (live_reg.delay - live_next.delay);
    allow_thr = {6'h00, cfg_reg.jit_allow[5:2], 2'b00};
  end

  // ==========================================================================
  // Next-state logic for measurement, alignment and registers
  // ==========================================================================
  always_comb begin
    cfg_next = cfg_reg;
    live_next = live_reg;
    snap_next = snap_reg;
    align_next = align_reg;
    align_cnt_next = align_cnt_reg;
    meas_cnt_next = meas_cnt_reg;
    meas_act_next = meas_act_reg;
    have_prev_next = have_prev_reg;
    tally_next = tally_reg;
    jit_flag_next = jit_flag_reg;
    jit_evt = 1'b0;
    lmfc_cnt_next = (lmfc_cnt_reg == `SRLM_LMFC_PERIOD - 12'h001) ? 12'h000 : lmfc_cnt_reg + 12'h001;

    // Software writes come first so that hardware events below win.
    if (REG_WR) begin
      case (REG_ADDR)
        `SRLM_OFF_IRQ_EN: cfg_next.jit_irq_en = REG_WDATA[`SRLM_BIT_JITTER];
        `SRLM_OFF_DSET_FRM: cfg_next.dset_frm = REG_WDATA[4:0];
        `SRLM_OFF_DSET_LO: cfg_next.dset_cyc[7:0] = REG_WDATA;
        `SRLM_OFF_DSET_HI: cfg_next.dset_cyc[11:8] = REG_WDATA[3:0];
        `SRLM_OFF_JIT_ALLOW: cfg_next.jit_allow = REG_WDATA[5:0];
        `SRLM_OFF_ALIGN_CTRL: cfg_next.mode = REG_WDATA[1:0];
        `SRLM_OFF_TX_GATE: begin
          cfg_next.gate_out = REG_WDATA[`SRLM_BIT_GATE_OUT];
          cfg_next.gate_in = REG_WDATA[`SRLM_BIT_GATE_IN];
        end
        `SRLM_OFF_IRQ_STAT: begin
          if (REG_WDATA[`SRLM_BIT_JITTER]) begin
            jit_flag_next = 1'b0;
          end
        end
        `SRLM_OFF_TALLY: tally_next = `SRLM_RST_ZERO8;
        default: begin
        end
      endcase
    end

    if (wr_snap) begin
      snap_next = live_reg;
    end

    if (meas_act_reg) begin
      if (lmfc_edge) begin
        meas_act_next = 1'b0;
        live_next.delay = {meas_cnt_reg[11:2], 2'b00};
        have_prev_next = 1'b1;
        if (have_prev_reg && diff > allow_thr) begin
          jit_evt = 1'b1;
        end
      end else if (meas_cnt_reg != 12'hfff) begin
        meas_cnt_next = meas_cnt_reg + 12'h001;
      end
    end

    if (ref_edge) begin
      meas_act_next = 1'b1;
      meas_cnt_next = 12'h000;
      live_next.phase = thermo;
      tally_next = tally_next + 8'h01;
    end

    if (jit_evt) begin
      jit_flag_next = 1'b1;
    end

    // Alignment: a pulse in a realigning mode arms the delay countdown.
    case (align_reg)
      SRLM_ALIGN_IDLE: begin
        if (ref_edge) begin
          if (cfg_reg.mode == `SRLM_MODE_CONT) begin
            align_next = SRLM_ALIGN_COUNT;
            align_cnt_next = target;
          end else if (cfg_reg.mode == `SRLM_MODE_ONESHOT) begin
            align_next = SRLM_ALIGN_COUNT;
            align_cnt_next = target;
            cfg_next.mode = `SRLM_MODE_MONITOR;
          end
        end
      end
      SRLM_ALIGN_COUNT: begin
        if (align_cnt_reg == 13'h0000) begin
          lmfc_cnt_next = 12'h000;
          align_next = SRLM_ALIGN_IDLE;
        end else begin
          align_cnt_next = align_cnt_reg - 13'h0001;
        end
      end
      default: align_next = SRLM_ALIGN_IDLE;
    endcase

    // Read data appear the cycle after the strobe; unmapped addresses read zero.
    rdata_next = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        `SRLM_OFF_IRQ_EN: rdata_next[`SRLM_BIT_JITTER] = cfg_reg.jit_irq_en;
        `SRLM_OFF_IRQ_STAT: rdata_next[`SRLM_BIT_JITTER] = jit_flag_reg;
        `SRLM_OFF_DSET_FRM: rdata_next = {3'h0, cfg_reg.dset_frm};
        `SRLM_OFF_DSET_LO: rdata_next = cfg_reg.dset_cyc[7:0];
        `SRLM_OFF_DSET_HI: rdata_next = {4'h0, cfg_reg.dset_cyc[11:8]};
        `SRLM_OFF_MEAS_LO: rdata_next = snap_reg.delay[7:0];
        `SRLM_OFF_MEAS_HI: rdata_next = {4'h0, snap_reg.delay[11:8]};
        `SRLM_OFF_TALLY: rdata_next = tally_reg;
        `SRLM_OFF_PHASE_LO: rdata_next = snap_reg.phase[7:0];
        `SRLM_OFF_PHASE_HI: rdata_next = {4'h0, snap_reg.phase[11:8]};
        `SRLM_OFF_JIT_ALLOW: rdata_next = {2'h0, cfg_reg.jit_allow};
        `SRLM_OFF_ALIGN_CTRL: rdata_next = {6'h00, cfg_reg.mode};
        `SRLM_OFF_TX_GATE: rdata_next = {cfg_reg.gate_out, cfg_reg.gate_in, 6'h00};
        default: rdata_next = 8'h00;
      endcase
    end

    dac_next = cfg_reg.gate_out ? DP_OUT_DATA : 16'h0000;
    dp_in_next = cfg_reg.gate_in ? LANE_DATA : 16'h0000;
    irq_next = jit_flag_next & cfg_next.jit_irq_en;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Every output is taken straight from a flip-flop; data and read outputs lag one cycle, while LMFC_EDGE and IRQ use next-state values and do not.
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      cfg_reg <= '{dset_frm: 5'h00, dset_cyc: 12'h000, jit_allow: 6'h00, mode: `SRLM_MODE_MONITOR,
                   gate_out: `SRLM_RST_GATE, gate_in: `SRLM_RST_GATE, jit_irq_en: 1'b0};
      live_reg <= '0;
      snap_reg <= '0;
      align_reg <= SRLM_ALIGN_IDLE;
      align_cnt_reg <= 13'h0000;
      lmfc_cnt_reg <= 12'h000;
      meas_cnt_reg <= 12'h000;
      meas_act_reg <= 1'b0;
      have_prev_reg <= 1'b0;
      tally_reg <= `SRLM_RST_ZERO8;
      jit_flag_reg <= 1'b0;
      REG_RDATA <= 8'h00;
      DP_IN_DATA <= 16'h0000;
      DAC_DATA <= 16'h0000;
      LMFC_EDGE <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      live_reg <= live_next;
      snap_reg <= snap_next;
      align_reg <= align_next;
      align_cnt_reg <= align_cnt_next;
      lmfc_cnt_reg <= lmfc_cnt_next;
      meas_cnt_reg <= meas_cnt_next;
      meas_act_reg <= meas_act_next;
      have_prev_reg <= have_prev_next;
      tally_reg <= tally_next;
      jit_flag_reg <= jit_flag_next;
      REG_RDATA <= rdata_next;
      DP_IN_DATA <= dp_in_next;
      DAC_DATA <= dac_next;
      LMFC_EDGE <= (lmfc_cnt_next == 12'h000);
      IRQ <= irq_next;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // All checks run on the block clock and sleep while the released reset is still low.
  // They watch internal state as well as pins, so a failure points at the stage that broke.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_sync);

  // A one-shot request seen by an idle aligner, and the state that must follow it.
  // The mode field and the aligner change together, so both are watched in one step.
  sequence s_oneshot_pulse;
    (cfg_reg.mode == `SRLM_MODE_ONESHOT) && (align_reg == SRLM_ALIGN_IDLE) && ref_edge;
  endsequence

  sequence s_reverted;
    (cfg_reg.mode == `SRLM_MODE_MONITOR) && (align_reg == SRLM_ALIGN_COUNT);
  endsequence

  a_delay_lsb_zero: assert property (live_reg.delay[1:0] == 2'b00 && snap_reg.delay[1:0] == 2'b00)
    else $error("measured delay low bits not zero");

  a_snap_hold: assert property (!wr_snap |=> $stable(snap_reg))
    else $error("snapshot changed without capture write");

  a_tally_clear: assert property ((REG_WR && REG_ADDR == `SRLM_OFF_TALLY && !ref_edge) |=> tally_reg == 8'h00)
    else $error("tally not cleared by write");

  a_phase_thermo: assert property (((live_reg.phase + 12'h001) & live_reg.phase) == 12'h000)
    else $error("phase not thermometer coded");

  // A clear in the following cycle is legal, so only the first cycle after the event is checked.
  a_jitter_flag_set: assert property (jit_evt |=> jit_flag_reg)
    else $error("jitter event did not set flag");

  a_monitor_no_align: assert property ((align_reg == SRLM_ALIGN_IDLE && ref_edge &&
    (cfg_reg.mode == `SRLM_MODE_MONITOR || cfg_reg.mode == 2'h3)) |=> align_reg == SRLM_ALIGN_IDLE)
    else $error("monitor mode started alignment");

  a_cont_realign: assert property ((align_reg == SRLM_ALIGN_IDLE && ref_edge &&
    cfg_reg.mode == `SRLM_MODE_CONT) |=> align_cnt_reg == $past(target) && align_reg == SRLM_ALIGN_COUNT)
    else $error("continuous mode did not realign");

  a_oneshot_revert: assert property ((s_oneshot_pulse and !REG_WR) |=> s_reverted)
    else $error("one-shot mode did not revert");

  a_out_gate: assert property (!cfg_reg.gate_out |=> DAC_DATA == 16'h0000)
    else $error("dac data not forced to zero");

  a_in_gate: assert property (cfg_reg.gate_in |=> DP_IN_DATA == $past(LANE_DATA))
    else $error("lane data not passed to datapath");

  a_irq_level: assert property (IRQ == (jit_flag_reg & cfg_reg.jit_irq_en))
    else $error("interrupt does not follow enabled flag");

  a_align_edge: assert property ((align_reg == SRLM_ALIGN_COUNT && align_cnt_reg == 13'h0000)
    |=> lmfc_cnt_reg == 12'h000 && LMFC_EDGE)
    else $error("frame edge not placed at programmed delay");

endmodule : srlm_top

//--- testbench/srlm_tx_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Transmitter side: reference pulses on request, lane data that changes every cycle.
module srlm_tx_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pulse request from the bench
  input wire logic fire,
  // Pins toward the receiver
  output logic sysref,
  output logic [15:0] lane_data
);
  logic [1:0] hold_reg;
  // A pulse lasts two cycles so that the receiver's synchroniser cannot miss it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= 2'h0;
      lane_data <= 16'h0000;
    end else begin
      hold_reg <= fire ? 2'h2 : ((hold_reg != 2'h0) ? hold_reg - 2'h1 : 2'h0);
      lane_data <= lane_data + 16'h1357;
    end
  end
  // The pin is a plain level, low between pulses.
  assign sysref = (hold_reg != 2'h0);
endmodule : srlm_tx_model

//--- testbench/sysref_lmfc_sync_monitor_tb.sv
`timescale 1ns/1ps
`include "srlm_consts.svh"
// ==========================================================================
// Bench for the reference alignment monitor.
module sysref_lmfc_sync_monitor_tb;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fire = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] v;
  logic [15:0] dp_out = 16'h0000;
  logic [15:0] lane, dp_in, dac, lv, dv;
  logic sysref, lmfc, irq;
  int cyc = 0;
  int num_errors = 0;
  int n_checks = 0;
  int l1, l28, lat, p, t_fire;

  // ==========================================================================
  // Clock, cycle count and a datapath output pattern.
  always #25 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    dp_out <= dp_out + 16'h0b1d;
  end

  srlm_tx_model tx_u (.clk(CLK), .rst_n(RST_N), .fire(fire), .sysref(sysref), .lane_data(lane));
  srlm_top dut_u (.CLK(CLK), .RST_N(RST_N), .SYSREF(sysref), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .LANE_DATA(lane), .DP_IN_DATA(dp_in),
    .DP_OUT_DATA(dp_out), .DAC_DATA(dac), .LMFC_EDGE(lmfc), .IRQ(irq));

  // ==========================================================================
  // Shared tasks.
  task results;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge CLK);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge CLK);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check($sformatf("reg %h", a), {8'h00, d}, {8'h00, exp});
  endtask : chk_rd

  task gates(input logic gi, input logic go);
    @(posedge CLK);
    #1 lv = lane;
    dv = dp_out;
    @(posedge CLK);
    #1 check("dp_in", dp_in, gi ? lv : 16'h0000);
    check("dac", dac, go ? dv : 16'h0000);
  endtask : gates

  task wait_lmfc;
    int i;
    #1;
    for (i = 0; i < 200 && lmfc !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    if (i == 200) begin
      num_errors++;
      $display("ERROR frame clock edge missing");
      results();
    end
  endtask : wait_lmfc

  // Fire a pulse at cycle t (at once if already past) and count cycles to the next frame clock edge.
  task fire_at(input int t, output int n);
    @(posedge CLK);
    while (cyc < t) @(posedge CLK);
    fire <= 1'b1;
    t_fire = cyc;
    @(posedge CLK);
    fire <= 1'b0;
    n = 1;
    #1;
    while (lmfc !== 1'b1 && n < 300) begin
      @(posedge CLK);
      #1 n++;
    end
    if (n == 300) begin
      num_errors++;
      $display("ERROR frame clock edge after pulse missing");
      results();
    end
  endtask : fire_at

  // ==========================================================================
  // Test sequence.
  initial begin
    logic [7:0] zaddr [12] = '{8'h20, 8'h24, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38,
      8'h39, 8'h3a};
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    foreach (zaddr[i]) chk_rd(zaddr[i], 8'h00); // reset values
    chk_rd(`SRLM_OFF_TX_GATE, 8'hc0); // gates reset on
    chk_rd(8'h10, 8'h00);
    $display("test reset values done");
    gates(1'b1, 1'b1); // both pass
    wr(`SRLM_OFF_TX_GATE, 8'h80);
    gates(1'b0, 1'b1); // input zeroed
    wr(`SRLM_OFF_TX_GATE, 8'h40);
    gates(1'b1, 1'b0); // output zeroed
    wr(`SRLM_OFF_TX_GATE, 8'hc0);
    $display("test gating done");
    wr(`SRLM_OFF_DSET_FRM, 8'h04);
    wr(`SRLM_OFF_DSET_LO, 8'h0c);
    wr(`SRLM_OFF_ALIGN_CTRL, 8'h02);
    wait_lmfc();
    fire_at(0, l28);
    chk_rd(`SRLM_OFF_ALIGN_CTRL, 8'h00); // one-shot reverts
    wr(`SRLM_OFF_DSET_LO, 8'h04);
    wr(`SRLM_OFF_ALIGN_CTRL, 8'h02);
    wait_lmfc();
    fire_at(0, l1);
    p = t_fire;
    check("align shift", 16'(l28 - l1), 16'h0008); // desired delay
    chk_rd(`SRLM_OFF_IRQ_STAT, 8'h10); // jitter latched
    check("irq masked", {15'h0000, irq}, 16'h0000); // masked
    wr(`SRLM_OFF_IRQ_EN, 8'h10);
    repeat (2) @(posedge CLK);
    #1 check("irq on", {15'h0000, irq}, 16'h0001); // enabled
    chk_rd(`SRLM_OFF_IRQ_EN, 8'h10);
    wr(`SRLM_OFF_IRQ_STAT, 8'h10);
    repeat (2) @(posedge CLK);
    #1 check("irq clr", {15'h0000, irq}, 16'h0000); // write one clears
    chk_rd(`SRLM_OFF_IRQ_STAT, 8'h00); // cleared
    $display("test one-shot alignment done");
    wr(`SRLM_OFF_JIT_ALLOW, 8'h0b);
    fire_at(p + 128, lat);
    check("monitor lat", 16'(lat), 16'(l1)); // no realign
    wr(`SRLM_OFF_MEAS_LO, 8'h00);
    chk_rd(`SRLM_OFF_MEAS_LO, 8'h14); // snapshot
    chk_rd(`SRLM_OFF_MEAS_HI, 8'h00); // high part
    fire_at(p + 264, lat);
    check("monitor lat2", 16'(lat), 16'(l1 - 8)); // no realign
    chk_rd(`SRLM_OFF_MEAS_LO, 8'h14); // held snapshot
    chk_rd(`SRLM_OFF_IRQ_STAT, 8'h00); // within allowance
    wr(`SRLM_OFF_PHASE_LO, 8'h00);
    chk_rd(`SRLM_OFF_MEAS_LO, 8'h0c); // new snapshot
    rd(`SRLM_OFF_PHASE_LO, v);
    check("thermometer", {8'h00, v & (v + 8'h01)}, 16'h0000); // thermometer code
    rd(`SRLM_OFF_PHASE_HI, v);
    check("phase high", {12'h000, v[7:4]}, 16'h0000); // unused upper nibble of high part
    wr(`SRLM_OFF_JIT_ALLOW, 8'h07);
    fire_at(p + 384, lat);
    chk_rd(`SRLM_OFF_IRQ_STAT, 8'h10); // beyond allowance
    check("irq jitter", {15'h0000, irq}, 16'h0001); // enabled request
    chk_rd(`SRLM_OFF_TALLY, 8'h05); // pulse count
    wr(`SRLM_OFF_TALLY, 8'h5a);
    chk_rd(`SRLM_OFF_TALLY, 8'h00); // write clears
    $display("test monitor and jitter done");
    wr(`SRLM_OFF_ALIGN_CTRL, 8'h01);
    wait_lmfc();
    fire_at(0, lat);
    check("cont lat", 16'(lat), 16'(l1)); // realign
    fire_at(t_fire + 77, lat);
    check("cont lat2", 16'(lat), 16'(l1)); // every pulse
    chk_rd(`SRLM_OFF_ALIGN_CTRL, 8'h01); // mode stays
    wr(`SRLM_OFF_ALIGN_CTRL, 8'h03);
    fire_at(t_fire + 50, lat);
    check("reserved lat", 16'(lat), 16'(l1 + 78)); // monitor only
    $display("test continuous and reserved done");
    results();
  end
endmodule : sysref_lmfc_sync_monitor_tb
